// *** rtl/exec_pkg.sv ***
package exec_pkg;

    // Opcodes of the handled instruction group
    localparam logic [7:0] OP_BIT_TEST = 8'h37;
    localparam logic [7:0] OP_BIT_XOR = 8'h27;
    localparam logic [7:0] OP_CALL_DIRECT = 8'hf6;
    localparam logic [7:0] OP_CALL_PAIR = 8'hf4;
    localparam logic [7:0] OP_CALL_INDIRECT = 8'hd4;
    localparam logic [7:0] OP_COMP_CARRY = 8'hef;
    localparam logic [7:0] OP_CLEAR_DIRECT = 8'hb0;
    localparam logic [7:0] OP_CLEAR_INDIRECT = 8'hb1;

    // Instruction lengths in bytes
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;

    // Execution times in clock cycles
    localparam logic [3:0] CYC_BIT_TEST = 4'ha;
    localparam logic [3:0] CYC_BIT_XOR = 4'h6;
    localparam logic [3:0] CYC_CALL_DIRECT = 4'he;
    localparam logic [3:0] CYC_CALL_PAIR = 4'hc;
    localparam logic [3:0] CYC_CALL_INDIRECT = 4'he;
    localparam logic [3:0] CYC_COMP_CARRY = 4'h4;
    localparam logic [3:0] CYC_CLEAR = 4'h4;

    // Bit positions inside the condition flags byte
    localparam int FLAG_CARRY = 7;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_SIGN = 5;
    localparam int FLAG_OVERFLOW = 4;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Memory port address spaces
    localparam logic [1:0] SPACE_REG = 2'h0;
    localparam logic [1:0] SPACE_STACK = 2'h1;
    localparam logic [1:0] SPACE_PROG = 2'h2;

    // Register index of the condition flags and APB byte addresses
    localparam logic [11:0] IDX_CONDITION_FLAGS = 12'h0d5;
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_INSTRUCTION = 12'h004;
    localparam logic [11:0] ADDR_PROG_COUNTER = 12'h008;
    localparam logic [11:0] ADDR_STACK_POINTER = 12'h00c;
    localparam logic [11:0] ADDR_WORK_BASE = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam logic [11:0] ADDR_CONDITION_FLAGS = 12'h354;

    // Control and status bit positions
    localparam int CTRL_GO = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_BAD_OP = 2;
    localparam int STAT_TAKEN = 3;

    // Reset values of software registers
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [7:0] WORK_BASE_RESET = 8'h00;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_A = 3'b001,
        ST_GET_A = 3'b010,
        ST_GET_B = 3'b011,
        ST_PUSH_HI = 3'b100,
        ST_WAIT = 3'b101
    } state_e;

endpackage : exec_pkg

// *** rtl/cycle_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module cycle_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Load a new cycle count
    input wire logic load_i,
    input wire logic [3:0] count_i,
    // Last cycle of the loaded count
    output logic expire_o
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    // Count down to zero after a load
    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign expire_o = (cnt_q == 4'h1);
endmodule : cycle_timer
`default_nettype wire

// *** rtl/bit_branch_call_clear_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module bit_branch_call_clear_exec
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Register file, stack and program memory port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [1:0] mem_space_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    // Execution status
    output logic busy_o
);
    state_e st_q, st_d;
    logic [23:0] ins_q, ins_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] newpc_q, newpc_d;
    logic [15:0] target_q, target_d;
    logic [7:0] flags_q, flags_d;
    logic [7:0] wbase_q, wbase_d;
    logic [7:0] a_q, a_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic bad_q, bad_d;
    logic taken_q, taken_d;
    logic req_q, req_d;
    logic we_q, we_d;
    logic [1:0] space_q, space_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic tmr_load;
    logic [3:0] tmr_count;
    logic tmr_expire;
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [2:0] bidx;
    logic res;
    logic [15:0] ret;
    logic [31:0] rd;
    logic known;
    logic locked;
    logic accept;

    // Address of a working register in the current bank
    function automatic logic [15:0] wreg(input logic [7:0] base,
                                         input logic [3:0] n);
        wreg = {8'h00, base[7:4], n};
    endfunction : wreg

    // Signed displacement widened to a program address
    function automatic logic [15:0] sext(input logic [7:0] d);
        sext = {{8{d[7]}}, d};
    endfunction : sext

    // Byte with one bit replaced
    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] i,
                                           input logic b);
        logic [7:0] r;
        r = v;
        r[i] = b;
        put_bit = r;
    endfunction : put_bit

    // Duration counter of the running instruction
    cycle_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .expire_o(tmr_expire)
    );

    // Instruction fields
    assign op = ins_q[7:0];
    assign b2 = ins_q[15:8];
    assign b3 = ins_q[23:16];
    assign bidx = b2[3:1];

    // Read data and decode of the APB address
    always_comb begin
        rd = 32'h0000_0000;
        known = 1'b1;
        locked = 1'b1;
        if (paddr_i == ADDR_CONTROL) begin
            rd = 32'h0000_0000;
        end else if (paddr_i == ADDR_INSTRUCTION) begin
            rd = {8'h00, ins_q};
        end else if (paddr_i == ADDR_PROG_COUNTER) begin
            rd = {16'h0000, pc_q};
        end else if (paddr_i == ADDR_STACK_POINTER) begin
            rd = {16'h0000, sp_q};
        end else if (paddr_i == ADDR_WORK_BASE) begin
            rd = {24'h00_0000, wbase_q};
        end else if (paddr_i == ADDR_STATUS) begin
            rd = {28'h000_0000, taken_q, bad_q, done_q, busy_q};
            locked = 1'b0;
        end else if (paddr_i == ADDR_CONDITION_FLAGS) begin
            rd = {24'h00_0000, flags_q};
        end else begin
            known = 1'b0;
        end
    end

    // Bus slave, register writes and the instruction sequencer
    always_comb begin
        st_d = st_q;
        ins_d = ins_q;
        pc_d = pc_q;
        sp_d = sp_q;
        newpc_d = newpc_q;
        target_d = target_q;
        flags_d = flags_q;
        wbase_d = wbase_q;
        a_d = a_q;
        busy_d = busy_q;
        done_d = done_q;
        bad_d = bad_q;
        taken_d = taken_q;
        req_d = 1'b0;
        we_d = 1'b0;
        space_d = space_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        tmr_load = 1'b0;
        tmr_count = 4'h0;
        res = 1'b0;
        ret = pc_q;
        // One wait state, answer taken on the second access cycle
        pready_d = psel_i & penable_i & ~pready_q;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        accept = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
        if (psel_i & penable_i & ~pready_q) begin
            prdata_d = pwrite_i ? 32'h0000_0000 : rd;
            pslverr_d = ~known | (pwrite_i & locked & busy_q);
        end
        if (accept) begin
            if (paddr_i == ADDR_INSTRUCTION) begin
                ins_d = pwdata_i[23:0];
            end else if (paddr_i == ADDR_PROG_COUNTER) begin
                pc_d = pwdata_i[15:0];
            end else if (paddr_i == ADDR_STACK_POINTER) begin
                sp_d = pwdata_i[15:0];
            end else if (paddr_i == ADDR_WORK_BASE) begin
                wbase_d = pwdata_i[7:0];
            end else if (paddr_i == ADDR_STATUS) begin
                done_d = done_q & ~pwdata_i[STAT_DONE];
                bad_d = bad_q & ~pwdata_i[STAT_BAD_OP];
                taken_d = taken_q & ~pwdata_i[STAT_TAKEN];
            end else if (paddr_i == ADDR_CONDITION_FLAGS) begin
                flags_d = pwdata_i[7:0];
            end
        end
        case (st_q)
            ST_IDLE: begin
                if (accept && paddr_i == ADDR_CONTROL &&
                    pwdata_i[CTRL_GO]) begin
                    busy_d = 1'b1;
                    tmr_load = 1'b1;
                    st_d = ST_WAIT_A;
                    req_d = 1'b1;
                    space_d = SPACE_REG;
                    case (op)
                        OP_BIT_TEST: begin
                            tmr_count = CYC_BIT_TEST;
                            newpc_d = pc_q + LEN_THREE;
                            addr_d = wreg(wbase_q, b2[7:4]);
                        end
                        OP_BIT_XOR: begin
                            tmr_count = CYC_BIT_XOR;
                            newpc_d = pc_q + LEN_THREE;
                            addr_d = wreg(wbase_q, b2[7:4]);
                        end
                        OP_CALL_DIRECT: begin
                            tmr_count = CYC_CALL_DIRECT;
                            ret = pc_q + LEN_THREE;
                            newpc_d = ret;
                            target_d = {b2, b3};
                            we_d = 1'b1;
                            space_d = SPACE_STACK;
                            addr_d = sp_q - 16'h0001;
                            wdata_d = ret[7:0];
                            st_d = ST_PUSH_HI;
                        end
                        OP_CALL_PAIR: begin
                            tmr_count = CYC_CALL_PAIR;
                            newpc_d = pc_q + LEN_TWO;
                            addr_d = {8'h00, b2};
                        end
                        OP_CALL_INDIRECT: begin
                            tmr_count = CYC_CALL_INDIRECT;
                            newpc_d = pc_q + LEN_TWO;
                            space_d = SPACE_PROG;
                            addr_d = {8'h00, b2};
                        end
                        OP_COMP_CARRY: begin
                            tmr_count = CYC_COMP_CARRY;
                            newpc_d = pc_q + LEN_ONE;
                            flags_d[FLAG_CARRY] = ~flags_q[FLAG_CARRY];
                            req_d = 1'b0;
                            st_d = ST_WAIT;
                        end
                        OP_CLEAR_DIRECT: begin
                            tmr_count = CYC_CLEAR;
                            newpc_d = pc_q + LEN_TWO;
                            we_d = 1'b1;
                            addr_d = {8'h00, b2};
                            wdata_d = 8'h00;
                            st_d = ST_WAIT;
                        end
                        OP_CLEAR_INDIRECT: begin
                            tmr_count = CYC_CLEAR;
                            newpc_d = pc_q + LEN_TWO;
                            addr_d = {8'h00, b2};
                        end
                        default: begin
                            busy_d = 1'b0;
                            tmr_load = 1'b0;
                            req_d = 1'b0;
                            bad_d = 1'b1;
                            st_d = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_WAIT_A: begin
                // Second operand read follows the first back to back
                st_d = ST_GET_A;
                if (op == OP_BIT_XOR) begin
                    req_d = 1'b1;
                    addr_d = {8'h00, b3};
                end else if (op == OP_CALL_PAIR) begin
                    req_d = 1'b1;
                    addr_d = {8'h00, b2 + 8'h01};
                end else if (op == OP_CALL_INDIRECT) begin
                    req_d = 1'b1;
                    addr_d = {8'h00, b2 + 8'h01};
                end
            end
            ST_GET_A: begin
                a_d = mem_rdata_i;
                st_d = ST_GET_B;
                if (op == OP_BIT_TEST) begin
                    // Sense bit chooses branch on set or on clear
                    if (mem_rdata_i[bidx] == b2[0]) begin
                        taken_d = 1'b1;
                        newpc_d = newpc_q + sext(b3);
                    end
                    st_d = ST_WAIT;
                end else if (op == OP_CLEAR_INDIRECT) begin
                    // Pointer register itself is only read
                    req_d = 1'b1;
                    we_d = 1'b1;
                    addr_d = {8'h00, mem_rdata_i};
                    wdata_d = 8'h00;
                    st_d = ST_WAIT;
                end
            end
            ST_GET_B: begin
                req_d = 1'b1;
                we_d = 1'b1;
                if (op == OP_BIT_XOR) begin
                    space_d = SPACE_REG;
                    if (!b2[0]) begin
                        res = a_q[0] ^ mem_rdata_i[bidx];
                        addr_d = wreg(wbase_q, b2[7:4]);
                        wdata_d = put_bit(a_q, 3'h0, res);
                    end else begin
                        res = mem_rdata_i[bidx] ^ a_q[0];
                        addr_d = {8'h00, b3};
                        wdata_d = put_bit(mem_rdata_i, bidx, res);
                    end
                    flags_d[FLAG_ZERO] = ~res;
                    flags_d[FLAG_SIGN] = 1'b0;
                    st_d = ST_WAIT;
                end else begin
                    // High byte came first, low byte second
                    target_d = {a_q, mem_rdata_i};
                    space_d = SPACE_STACK;
                    addr_d = sp_q - 16'h0001;
                    wdata_d = newpc_q[7:0];
                    st_d = ST_PUSH_HI;
                end
            end
            ST_PUSH_HI: begin
                req_d = 1'b1;
                we_d = 1'b1;
                space_d = SPACE_STACK;
                addr_d = sp_q - 16'h0002;
                wdata_d = newpc_q[15:8];
                sp_d = sp_q - 16'h0002;
                newpc_d = target_q;
                st_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (tmr_expire) begin
                    pc_d = newpc_q;
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            ins_q <= 24'h00_0000;
            pc_q <= PC_RESET;
            sp_q <= SP_RESET;
            newpc_q <= PC_RESET;
            target_q <= 16'h0000;
            flags_q <= FLAGS_RESET;
            wbase_q <= WORK_BASE_RESET;
            a_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            bad_q <= 1'b0;
            taken_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            space_q <= SPACE_REG;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ins_q <= ins_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            newpc_q <= newpc_d;
            target_q <= target_d;
            flags_q <= flags_d;
            wbase_q <= wbase_d;
            a_q <= a_d;
            busy_q <= busy_d;
            done_q <= done_d;
            bad_q <= bad_d;
            taken_q <= taken_d;
            req_q <= req_d;
            we_q <= we_d;
            space_q <= space_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign mem_req_o = req_q;
    assign mem_we_o = we_q;
    assign mem_space_o = space_q;
    assign mem_addr_o = addr_q;
    assign mem_wdata_o = wdata_q;
    assign busy_o = busy_q;
endmodule : bit_branch_call_clear_exec
`default_nettype wire

// *** test/exec_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module exec_properties
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    // Memory port and status
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [1:0] mem_space_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic stk_wr;
    // Stack pushes seen at the memory port
    assign stk_wr = mem_req_o && mem_we_o && mem_space_o == SPACE_STACK;
    pready_one_a: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    pready_wait_a: assert property (psel_i && penable_i && !pready_o
        |=> pready_o) else $error("second access cycle without ready");
    busy_min_a: assert property ($rose(busy_o) |-> busy_o [*4])
        else $error("instruction shorter than four cycles");
    busy_max_a: assert property ($rose(busy_o) |-> ##[4:14] !busy_o)
        else $error("instruction longer than fourteen cycles");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(psel_i &&
        penable_i && pready_o && pwrite_i && paddr_i == ADDR_CONTROL
        && pwdata_i[CTRL_GO])) else $error("busy without a go write");
    mem_idle_a: assert property (mem_req_o |-> busy_o)
        else $error("memory access while idle");
    push_order_a: assert property (stk_wr && !$past(stk_wr) |=>
        stk_wr && mem_addr_o == $past(mem_addr_o) - 16'h0001)
        else $error("second push not one below the first");
    stack_write_a: assert property (mem_req_o &&
        mem_space_o == SPACE_STACK |-> mem_we_o)
        else $error("stack read by this group");
    prog_read_a: assert property (mem_req_o &&
        mem_space_o == SPACE_PROG |-> !mem_we_o)
        else $error("program memory written");
endmodule : exec_properties
bind bit_branch_call_clear_exec exec_properties chk (.clk_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
    .mem_req_o, .mem_we_o, .mem_space_o, .mem_addr_o, .busy_o);
`default_nettype wire

// *** test/bit_branch_call_clear_exec_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    logic [33:0] ev, gv; \
    ev = (e); \
    gv = (g); \
    samples_checked++; \
    if (ev !== gv) begin \
        fails++; \
        $display("unexpected %s exp %h got %h", nm, ev, gv); \
    end \
end
module bit_branch_call_clear_exec_tb_top;
    import exec_pkg::*;
    logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o;
    logic pready_o, pslverr_o, mem_req_o, mem_we_o, busy_o;
    logic [1:0] mem_space_o;
    logic [15:0] mem_addr_o, pc, sp, t, r;
    logic [7:0] mem_wdata_o, mem_rdata_i = 8'h5a, fl, v, s, d, a, p;
    logic [7:0] regf [256], prog [256];
    logic [33:0] apb_q [$], n;
    logic [25:0] wr_q [$];
    int cyc_q [$], fails = 0, samples_checked = 0, bcnt = 0;
    logic [2:0] b;
    logic [3:0] k;
    logic res;
    bit_branch_call_clear_exec DUT (.clk_i, .rst_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .mem_req_o, .mem_we_o, .mem_space_o, .mem_addr_o, .mem_wdata_o,
        .mem_rdata_i, .busy_o);
    always #12.5 clk_i = ~clk_i;
    // Memory responder and write monitor; idle data toggles
    always @(posedge clk_i) begin
        if (mem_req_o === 1'b1 && mem_we_o === 1'b0)
            mem_rdata_i <= (mem_space_o == SPACE_PROG) ?
                prog[mem_addr_o[7:0]] : regf[mem_addr_o[7:0]];
        else
            mem_rdata_i <= ~mem_rdata_i;
        if (mem_req_o === 1'b1 && mem_we_o === 1'b1) begin
            `CHK("mem write", wr_q.pop_front(),
                {mem_space_o, mem_addr_o, mem_wdata_o})
            if (mem_space_o == SPACE_REG)
                regf[mem_addr_o[7:0]] = mem_wdata_o;
        end
    end
    // APB result and busy length watchers
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            n = apb_q.pop_front();
            `CHK("pslverr", n[32], pslverr_o)
            if (n[33])
                `CHK("prdata", n[31:0], prdata_o)
        end
        if (rst_i)
            bcnt = 0;
        else if (busy_o === 1'b1)
            bcnt++;
        else if (bcnt != 0) begin
            `CHK("busy cycles", cyc_q.pop_front(), bcnt)
            bcnt = 0;
        end
    end
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] dt);
        int c;
        c = 0;
        @(posedge clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= dt;
        @(posedge clk_i) penable_i <= 1;
        do begin
            @(posedge clk_i);
            c++;
        end while (pready_o !== 1'b1 && c < 20);
        if (c >= 20)
            fails++;
        psel_i <= 0;
        penable_i <= 0;
    endtask : apb
    task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                      input logic err = 0);
        apb_q.push_back({1'b1, err, e});
        apb(0, ad, 32'h0);
    endtask : rd
    task automatic wr(input logic [11:0] ad, input logic [31:0] dt,
                      input logic err = 0);
        apb_q.push_back({1'b0, err, 32'h0});
        apb(1, ad, dt);
    endtask : wr
    task automatic run(input logic [23:0] ins, input int cy,
                       input logic poke = 0);
        int c;
        c = 0;
        wr(ADDR_INSTRUCTION, {8'h00, ins});
        wr(ADDR_PROG_COUNTER, {16'h0000, pc});
        cyc_q.push_back(cy);
        wr(ADDR_CONTROL, 32'h1);
        if (poke)
            wr(ADDR_PROG_COUNTER, 32'h0, 1);
        do begin
            @(posedge clk_i);
            c++;
        end while (busy_o !== 1'b0 && c < 40);
        if (c >= 40)
            fails++;
    endtask : run
    task automatic print_verdict;
        // Let the watchers take the last answers first
        repeat (2) @(posedge clk_i);
        `CHK("pending", 0, cyc_q.size() + wr_q.size() + apb_q.size())
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
    // Test sequence
    initial begin
        void'($urandom(32'h2af56506));
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        rd(ADDR_STACK_POINTER, 32'h0);
        rd(ADDR_CONDITION_FLAGS, 32'h0);
        rd(12'h020, 32'h0, 1);
        fl = $urandom;
        wr(ADDR_CONDITION_FLAGS, {24'h0, fl});
        wr(ADDR_WORK_BASE, 32'hc0);
        pc = $urandom;
        run({16'h0000, OP_COMP_CARRY}, 4);
        fl[FLAG_CARRY] = ~fl[FLAG_CARRY];
        rd(ADDR_CONDITION_FLAGS, {24'h0, fl});
        rd(ADDR_PROG_COUNTER, {16'h0, pc + LEN_ONE});
        $display("test complement carry done");
        // Unknown opcode: flagged, no execution
        wr(ADDR_INSTRUCTION, 32'h0);
        wr(ADDR_CONTROL, 32'h1);
        rd(ADDR_STATUS, 32'h6);
        wr(ADDR_STATUS, 32'he);
        for (int i = 0; i < 4; i++) begin
            k = $urandom;
            b = $urandom;
            v = $urandom;
            d = i[1] ? 8'h80 : 8'h7f;
            pc = $urandom;
            regf[{4'hc, k}] = v;
            res = (v[b] == i[0]);
            t = pc + LEN_THREE + (res ? {{8{d[7]}}, d} : 16'h0);
            run({d, k, b, i[0], OP_BIT_TEST}, 10, i == 0);
            rd(ADDR_PROG_COUNTER, {16'h0, t});
            rd(ADDR_CONDITION_FLAGS, {24'h0, fl});
            rd(ADDR_STATUS, {28'h0, res, 3'b010});
            wr(ADDR_STATUS, 32'he);
        end
        $display("test bit branch done");
        for (int i = 0; i < 2; i++) begin
            k = $urandom;
            b = $urandom;
            v = $urandom;
            s = $urandom;
            a = $urandom % 64;
            pc = $urandom;
            regf[{4'hc, k}] = v;
            regf[a] = s;
            res = v[0] ^ s[b];
            if (i == 0)
                wr_q.push_back({SPACE_REG, 8'h00, 4'hc, k, v[7:1], res});
            else begin
                s[b] = res;
                wr_q.push_back({SPACE_REG, 8'h00, a, s});
            end
            run({a, k, b, i[0], OP_BIT_XOR}, 6);
            fl[FLAG_ZERO] = ~res;
            fl[FLAG_SIGN] = 0;
            rd(ADDR_CONDITION_FLAGS, {24'h0, fl});
            rd(ADDR_PROG_COUNTER, {16'h0, pc + LEN_THREE});
        end
        $display("test bit exclusive or done");
        for (int i = 0; i < 3; i++) begin
            sp = 16'h0080 + $urandom % 64;
            t = $urandom;
            a = $urandom % 64;
            pc = $urandom;
            {regf[a], regf[a + 8'h1]} = t;
            {prog[a], prog[a + 8'h1]} = t;
            r = pc + ((i == 0) ? LEN_THREE : LEN_TWO);
            wr(ADDR_STACK_POINTER, {16'h0, sp});
            wr_q.push_back({SPACE_STACK, sp - 16'h1, r[7:0]});
            wr_q.push_back({SPACE_STACK, sp - 16'h2, r[15:8]});
            case (i)
                0: run({t[7:0], t[15:8], OP_CALL_DIRECT}, 14);
                1: run({8'h00, a, OP_CALL_PAIR}, 12);
                default: run({8'h00, a, OP_CALL_INDIRECT}, 14);
            endcase
            rd(ADDR_PROG_COUNTER, {16'h0, t});
            rd(ADDR_STACK_POINTER, {16'h0, sp - 16'h2});
            rd(ADDR_CONDITION_FLAGS, {24'h0, fl});
        end
        $display("test call done");
        for (int i = 0; i < 2; i++) begin
            a = $urandom % 64;
            p = 8'h40 + $urandom % 64;
            pc = $urandom;
            regf[a] = p;
            regf[p] = 8'hff;
            wr_q.push_back({SPACE_REG, 8'h00, i ? p : a, 8'h00});
            run({8'h00, a, i ? OP_CLEAR_INDIRECT : OP_CLEAR_DIRECT}, 4);
            rd(ADDR_PROG_COUNTER, {16'h0, pc + LEN_TWO});
            rd(ADDR_CONDITION_FLAGS, {24'h0, fl});
            if (i)
                `CHK("pointer", p, regf[a])
        end
        $display("test clear done");
        print_verdict();
    end
endmodule : bit_branch_call_clear_exec_tb_top
`default_nettype wire
